// File: pfcc_pkg.sv
package pfcc_pkg;

  // ----------------------------------------
  // Sizes and register map
  // ----------------------------------------
  localparam int PFCC_NPRIO = 8;
  localparam logic [7:0] PFCC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PFCC_OFF_NODROP = 8'h04;
  localparam logic [7:0] PFCC_OFF_XOFF = 8'h08;
  localparam logic [7:0] PFCC_OFF_XON = 8'h0c;
  localparam logic [7:0] PFCC_OFF_PTIME = 8'h10;
  localparam logic [7:0] PFCC_OFF_STAT = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PFCC_CTRL_PFC = 0;
  localparam int PFCC_CTRL_LFC = 1;
  localparam int PFCC_STAT_HOLD = 8;
  localparam int PFCC_STAT_LHOLD = 16;
  localparam int PFCC_STAT_LFCACT = 17;
  localparam int PFCC_STAT_INGR = 18;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] PFCC_CTRL_RST = 2'h0;
  localparam logic [7:0] PFCC_NODROP_RST = 8'h00;
  localparam logic [15:0] PFCC_XOFF_RST = 16'h0100;
  localparam logic [15:0] PFCC_XON_RST = 16'h0080;
  localparam logic [15:0] PFCC_PTIME_RST = 16'hffff;

  // ----------------------------------------
  // Timing: one pause quantum is 512 bit times
  // ----------------------------------------
  localparam int PFCC_CLK_PS = 10000;
  localparam int PFCC_QUANTUM_PS = 51200;
  localparam int PFCC_QUANTA_CYC = (PFCC_QUANTUM_PS / PFCC_CLK_PS < 1) ? 1 :
                                   PFCC_QUANTUM_PS / PFCC_CLK_PS;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] vec;     // Class enable vector
    logic [7:0] xoff;    // Classes given nonzero time
    logic [15:0] quanta; // Time for xoff classes
  } pfcc_txreq_t;

  typedef struct packed {
    logic valid;         // One-cycle frame strobe
    logic is_pfc;        // Per-priority frame, else link-wide
    logic [7:0] vec;     // Class enable vector
    logic [15:0] quanta; // Requested time
  } pfcc_rxpause_t;

endpackage

// File: pfcc_ctrl.sv
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Classify frames into pause classes by VLAN priority code.
// - Per-priority pause uses its own frame kind, not the link-wide one.
// - Enabling per-priority control switches off link-wide pause.
// - Disabling per-priority control restores stored link-wide setting.
// - Link-wide pause frames ignored while per-priority control enabled.
// - Each priority holds a drop or no-drop setting.
// - Congested no-drop priority makes a pause request to partner.
// - Drop priorities never cause pause requests.
// - After reset no no-drop priority and per-priority control off.
// - Pause sent at threshold before buffer exhausted, headroom left.
// - Enabled per-priority control forces ingress congestion control.
// - Enabled but no no-drop priority gives no pause requests.
// - Port without per-priority control ignores per-priority frames.
module pfcc_ctrl
  import pfcc_pkg::*;
#(
  parameter int CNT_W = 16,                 // Occupancy counter width
  parameter int QUANTA_CYC = PFCC_QUANTA_CYC // Cycles per pause quantum
) (
  input wire logic clk_i,                   // System clock
  input wire logic rst_i,                   // Sync reset, high
  input wire logic [7:0] adr_i,             // Wishbone address
  input wire logic [31:0] dat_i,            // Wishbone write data
  output logic [31:0] dat_o,                // Wishbone read data
  input wire logic we_i,                    // Wishbone write
  input wire logic [3:0] sel_i,             // Wishbone byte enables
  input wire logic stb_i,                   // Wishbone strobe
  input wire logic cyc_i,                   // Wishbone cycle
  output logic ack_o,                       // Wishbone ack
  input wire logic rx_frame_i,              // Frame admitted to buffer
  input wire logic [2:0] rx_pcp_i,          // Its VLAN priority
  input wire logic rel_i,                   // Frame released from buffer
  input wire logic [2:0] rel_pcp_i,         // Its VLAN priority
  input wire pfcc_rxpause_t rx_pause_i,     // Parsed pause frame
  output pfcc_txreq_t tx_req_o,             // Pause frame to send
  output logic tx_req_valid_o,              // Request pending
  input wire logic tx_req_ack_i,            // Request taken by MAC
  output logic [7:0] tx_hold_o,             // Per-class transmit stop
  output logic link_hold_o,                 // Link-wide transmit stop
  output logic lfc_active_o,                // Link-wide pause in effect
  output logic ingress_cc_o                 // Ingress congestion mode
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = nw[7:0];
    end
    if (be[1]) begin
      r[15:8] = nw[15:8];
    end
    return r;
  endfunction

  typedef enum logic {PFCC_IDLE, PFCC_BUSY} pfcc_st_t;

  logic [1:0] ctrl_q;
  logic [7:0] nodrop_q;
  logic [15:0] xoff_thr_q;
  logic [15:0] xon_thr_q;
  logic [15:0] ptime_q;
  logic pfc_en;
  logic wb_take;
  logic [31:0] rdata;
  logic [CNT_W-1:0] cnt_q [PFCC_NPRIO];
  logic [15:0] tmr_q [PFCC_NPRIO];
  logic [15:0] ltmr_q;
  logic [7:0] xoff_q;
  logic [7:0] sent_q;
  logic [15:0] qdiv_q;
  logic tick_q;
  pfcc_st_t st_q;

  assign pfc_en = ctrl_q[PFCC_CTRL_PFC];
  assign wb_take = cyc_i & stb_i & ~ack_o;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // One-cycle answer; ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_take;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0;
    unique case (adr_i)
      PFCC_OFF_CTRL: rdata[1:0] = ctrl_q;
      PFCC_OFF_NODROP: rdata[7:0] = nodrop_q;
      PFCC_OFF_XOFF: rdata[15:0] = xoff_thr_q;
      PFCC_OFF_XON: rdata[15:0] = xon_thr_q;
      PFCC_OFF_PTIME: rdata[15:0] = ptime_q;
      PFCC_OFF_STAT: begin
        rdata[7:0] = xoff_q;
        rdata[PFCC_STAT_HOLD +: 8] = tx_hold_o;
        rdata[PFCC_STAT_LHOLD] = link_hold_o;
        rdata[PFCC_STAT_LFCACT] = lfc_active_o;
        rdata[PFCC_STAT_INGR] = ingress_cc_o;
      end
      default: rdata = 32'h0;
    endcase
  end

  // Read data latched with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (wb_take && !we_i) begin
      dat_o <= rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= PFCC_CTRL_RST;
      nodrop_q <= PFCC_NODROP_RST;
      xoff_thr_q <= PFCC_XOFF_RST;
      xon_thr_q <= PFCC_XON_RST;
      ptime_q <= PFCC_PTIME_RST;
    end else if (wb_take && we_i) begin
      unique case (adr_i)
        PFCC_OFF_CTRL: begin
          if (sel_i[0]) begin
            ctrl_q <= dat_i[1:0];
          end
        end
        PFCC_OFF_NODROP: begin
          if (sel_i[0]) begin
            nodrop_q <= dat_i[7:0];
          end
        end
        PFCC_OFF_XOFF: xoff_thr_q <= wmerge(xoff_thr_q, dat_i, sel_i);
        PFCC_OFF_XON: xon_thr_q <= wmerge(xon_thr_q, dat_i, sel_i);
        PFCC_OFF_PTIME: ptime_q <= wmerge(ptime_q, dat_i, sel_i);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  // per-priority mode masks link-wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfc_active_o <= 1'b0;
      ingress_cc_o <= 1'b0;
    end else begin
      lfc_active_o <= ctrl_q[PFCC_CTRL_LFC] & ~pfc_en;
      ingress_cc_o <= pfc_en;
    end
  end

  // Pause quantum tick divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qdiv_q <= 16'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (qdiv_q == 16'(QUANTA_CYC - 1));
      qdiv_q <= (qdiv_q == 16'(QUANTA_CYC - 1)) ? 16'h0 : qdiv_q + 16'h1;
    end
  end

  // ----------------------------------------
  // Per-class congestion and receive timers
  // ----------------------------------------
  generate
    for (genvar i = 0; i < PFCC_NPRIO; i++) begin : g_cls
      logic inc;
      logic dec;
      logic lossless;
      assign inc = rx_frame_i && (rx_pcp_i == 3'(i));
      assign dec = rel_i && (rel_pcp_i == 3'(i));
      assign lossless = nodrop_q[i] & pfc_en;

      // Occupancy, saturating both ways
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q[i] <= '0;
        end else if (inc && !dec && cnt_q[i] != '1) begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end else if (dec && !inc && cnt_q[i] != '0) begin
          cnt_q[i] <= cnt_q[i] - 1'b1;
        end
      end

      // xoff set below buffer size for headroom
      always_ff @(posedge clk_i) begin
        if (rst_i || !lossless) begin
          xoff_q[i] <= 1'b0;
        end else if (cnt_q[i] >= CNT_W'(xoff_thr_q)) begin
          xoff_q[i] <= 1'b1;
        end else if (cnt_q[i] <= CNT_W'(xon_thr_q)) begin
          xoff_q[i] <= 1'b0;
        end
      end

      // Every class checked, not only the one a scenario happens to load
      chk_congest_pause: assert property (@(posedge clk_i) disable iff (rst_i)
        (nodrop_q[i] && pfc_en && cnt_q[i] >= CNT_W'(xoff_thr_q)) |=> xoff_q[i])
        else $error("congested class not paused");

      always_ff @(posedge clk_i) begin
        if (rst_i || !pfc_en) begin
          tmr_q[i] <= 16'h0;
        end else if (rx_pause_i.valid && rx_pause_i.is_pfc && rx_pause_i.vec[i]) begin
          tmr_q[i] <= rx_pause_i.quanta;
        end else if (tick_q && tmr_q[i] != 16'h0) begin
          tmr_q[i] <= tmr_q[i] - 16'h1;
        end
      end

      // Hold follows the timer one cycle late
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tx_hold_o[i] <= 1'b0;
        end else begin
          tx_hold_o[i] <= (tmr_q[i] != 16'h0);
        end
      end
    end
  endgenerate

  // link-wide frames dropped in per-priority mode
  // the two frame kinds never cross
  always_ff @(posedge clk_i) begin
    if (rst_i || !lfc_active_o) begin
      ltmr_q <= 16'h0;
    end else if (rx_pause_i.valid && !rx_pause_i.is_pfc) begin
      ltmr_q <= rx_pause_i.quanta;
    end else if (tick_q && ltmr_q != 16'h0) begin
      ltmr_q <= ltmr_q - 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_hold_o <= 1'b0;
    end else begin
      link_hold_o <= lfc_active_o && (ltmr_q != 16'h0);
    end
  end

  // ----------------------------------------
  // Transmit request sequencer
  // ----------------------------------------
  // Sends only the classes whose state moved; one frame in flight
  // zero time for resumed classes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= PFCC_IDLE;
      sent_q <= 8'h0;
      tx_req_valid_o <= 1'b0;
      tx_req_o <= '0;
    end else begin
      unique case (st_q)
        PFCC_IDLE: begin
          if (xoff_q != sent_q) begin
            tx_req_o.vec <= xoff_q ^ sent_q;
            tx_req_o.xoff <= xoff_q;
            tx_req_o.quanta <= ptime_q;
            sent_q <= xoff_q;
            tx_req_valid_o <= 1'b1;
            st_q <= PFCC_BUSY;
          end
        end
        PFCC_BUSY: begin
          if (tx_req_ack_i) begin
            tx_req_valid_o <= 1'b0;
            st_q <= PFCC_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_lfc_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    pfc_en |=> !lfc_active_o) else $error("link pause active with pfc on");

  chk_lfc_restored: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pfc_en && ctrl_q[PFCC_CTRL_LFC]) [*2] |-> lfc_active_o)
    else $error("link pause not restored");

  chk_lfc_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    pfc_en [*3] |-> !link_hold_o) else $error("link pause honoured in pfc mode");

  chk_pfc_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    !pfc_en [*2] |-> tx_hold_o == 8'h0) else $error("pfc frame honoured while off");

  chk_reset_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (nodrop_q == 8'h0 && !pfc_en)) else $error("bad reset config");

  chk_ingress_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pfc_en) |=> ingress_cc_o ##0 (ingress_cc_o == pfc_en || $fell(pfc_en)))
    else $error("ingress mode not entered");

  chk_no_lossless: assert property (@(posedge clk_i) disable iff (rst_i)
    (nodrop_q == 8'h0) [*2] |-> xoff_q == 8'h0) else $error("pause with no lossless class");

  chk_drop_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_req_valid_o) |-> (tx_req_o.xoff & ~$past(nodrop_q, 2)) == 8'h0)
    else $error("drop class paused");

  chk_rx_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (pfc_en && rx_pause_i.valid && rx_pause_i.is_pfc && rx_pause_i.quanta > 16'h2)
    ##1 pfc_en |=> (tx_hold_o & $past(rx_pause_i.vec, 2)) == $past(rx_pause_i.vec, 2))
    else $error("indicated class not held");

  chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack longer than one cycle");

endmodule // pfcc_ctrl

// File: pfcc_partner.sv
`timescale 1ns/1ps
// ------
// Link partner MAC model
// ------
module pfcc_partner
  import pfcc_pkg::*;
(
  input wire logic clk_i,           // Clock
  input wire logic rst_i,           // Sync reset
  input wire pfcc_txreq_t req_i,    // Pause request from port
  input wire logic req_valid_i,     // Request pending
  output logic req_ack_o,           // Request taken
  input wire logic [3:0] dly_i,     // Ack delay, cycles
  input wire logic send_i,          // Send one pause frame
  input wire logic pfc_i,           // Frame kind
  input wire logic [7:0] vec_i,     // Classes to pause
  input wire logic [15:0] quanta_i, // Pause time
  output pfcc_rxpause_t pause_o,    // Frame seen by port
  output pfcc_txreq_t last_o,       // Last request taken
  output logic [7:0] taken_o        // Requests taken
);
  logic [3:0] wait_q;

  // Ack after a chosen delay, held until the port sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ack_o <= 1'b0;
      wait_q <= 4'h0;
      taken_o <= 8'h00;
      last_o <= '0;
    end else if (req_ack_o && req_valid_i) begin
      req_ack_o <= 1'b0;
      last_o <= req_i;
      taken_o <= taken_o + 8'h01;
    end else if (req_valid_i && wait_q >= dly_i) begin
      req_ack_o <= 1'b1;
      wait_q <= 4'h0;
    end else if (req_valid_i) begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // distinct frame kinds
  // Idle fields toggle so stale values never pass for a frame
  always_ff @(posedge clk_i) begin
    if (rst_i) pause_o <= '0;
    else if (send_i) pause_o <= {1'b1, pfc_i, vec_i, quanta_i};
    else pause_o <= {1'b0, ~pause_o.is_pfc, ~pause_o.vec, ~pause_o.quanta};
  end
endmodule // pfcc_partner

// File: pfcc_ctrl_tb.sv
`timescale 1ns/1ps
module pfcc_ctrl_tb
  import pfcc_pkg::*;
;
  logic clk_i, rst_i = 1'b1, we_i = 1'b0, stb_i = 1'b0, cyc_i = 1'b0, ack_o, tx_ack;
  logic rx_frame_i = 1'b0, rel_i = 1'b0, send = 1'b0, pfc = 1'b0;
  logic [7:0] adr_i = 8'h00, vec = 8'h00, n0 = 8'h00, tx_hold_o, taken;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'h3, dly = 4'h0;
  logic [2:0] rx_pcp_i = 3'h0, rel_pcp_i = 3'h0;
  logic [15:0] quanta = 16'h0, pq;
  logic tx_req_valid_o, link_hold_o, lfc_active_o, ingress_cc_o;
  pfcc_rxpause_t rx_pause;
  pfcc_txreq_t tx_req, last;
  int bad_count = 0, n_tests = 0, c, len;
  logic [7:0] offs [7] = '{PFCC_OFF_CTRL, PFCC_OFF_NODROP, PFCC_OFF_XOFF, PFCC_OFF_XON,
                           PFCC_OFF_PTIME, PFCC_OFF_STAT, 8'h20};
  logic [31:0] rstv [7] = '{32'(PFCC_CTRL_RST), 32'(PFCC_NODROP_RST), 32'(PFCC_XOFF_RST),
                            32'(PFCC_XON_RST), 32'(PFCC_PTIME_RST), 32'h0, 32'h0};

  // ------
  // Design and partner
  // ------
  pfcc_ctrl #(.CNT_W(8), .QUANTA_CYC(2)) u_pfcc_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i),
    .cyc_i(cyc_i), .ack_o(ack_o), .rx_frame_i(rx_frame_i), .rx_pcp_i(rx_pcp_i), .rel_i(rel_i),
    .rel_pcp_i(rel_pcp_i), .rx_pause_i(rx_pause), .tx_req_o(tx_req),
    .tx_req_valid_o(tx_req_valid_o), .tx_req_ack_i(tx_ack), .tx_hold_o(tx_hold_o),
    .link_hold_o(link_hold_o), .lfc_active_o(lfc_active_o), .ingress_cc_o(ingress_cc_o));
  pfcc_partner u_pfcc_partner (.clk_i(clk_i), .rst_i(rst_i), .req_i(tx_req),
    .req_valid_i(tx_req_valid_o), .req_ack_o(tx_ack), .dly_i(dly), .send_i(send),
    .pfc_i(pfc), .vec_i(vec), .quanta_i(quanta), .pause_o(rx_pause), .last_o(last),
    .taken_o(taken));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // A wait that runs out ends the run
  task automatic timeout();
    check(32'h0, 32'h1);
    finish_test();
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    n0 = 8'h00;
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (!ack_o && i < 20);
    if (ack_o !== 1'b1) timeout();
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // Admit (up) or release n frames of one class
  task automatic push(input logic up, input logic [2:0] p, input int n);
    repeat (n) begin
      @(posedge clk_i);
      rx_frame_i <= up;
      rel_i <= !up;
      rx_pcp_i <= p;
      rel_pcp_i <= p;
    end
    @(posedge clk_i);
    rx_frame_i <= 1'b0;
    rel_i <= 1'b0;
  endtask

  // Partner sends one frame; hold is due one edge after the port takes it
  task automatic pause(input logic k, input logic [7:0] v, input logic [15:0] q);
    @(posedge clk_i);
    send <= 1'b1;
    pfc <= k;
    vec <= v;
    quanta <= q;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic wait_req(input logic [7:0] v, input logic [7:0] x);
    for (int i = 0; i < 80 && taken == n0; i++) @(posedge clk_i);
    if (taken == n0) timeout();
    n0 = taken;
    check(last.vec, v); // classes moved
    check(last.xoff, x); // classes paused
  endtask

  initial begin
    void'($urandom(32'hf4b6));
    do_reset();
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, offs[i], 32'h0);
      check(rd, rstv[i]); // reset value
    end
    check({tx_req_valid_o, tx_hold_o, link_hold_o, lfc_active_o, ingress_cc_o}, 0); // idle
    $display("test reset done");
    // Link-wide mode alone, then per-priority on top of it
    wb(1'b1, PFCC_OFF_CTRL, 32'h2);
    repeat (3) @(posedge clk_i);
    wb(1'b0, PFCC_OFF_STAT, 32'h0);
    check(rd[18:16], 3'b010); // stored mode
    pause(1'b0, 8'h00, 16'h0010);
    check(link_hold_o, 1'b1); // link pause
    pause(1'b1, 8'hff, 16'h0010);
    check(tx_hold_o, 8'h00); // frames ignored
    wb(1'b1, PFCC_OFF_CTRL, 32'h3);
    repeat (3) @(posedge clk_i);
    wb(1'b0, PFCC_OFF_STAT, 32'h0);
    check(rd[18:16], 3'b100); // mode swap
    pause(1'b0, 8'h00, 16'h0010);
    check(link_hold_o, 1'b0); // link frame ignored
    wb(1'b1, PFCC_OFF_XOFF, 32'h4);
    c = $urandom % 8;
    push(1'b1, 3'(c), 6);
    repeat (10) @(posedge clk_i);
    check(taken, n0); // no lossless class
    $display("test modes done");
    // Threshold pause and resume on one lossless class
    do_reset();
    dly <= 4'($urandom % 6);
    pq = 16'($urandom) | 16'h0001;
    // High lane only: low byte must keep its reset value
    sel_i <= 4'h2;
    wb(1'b1, PFCC_OFF_XON, 32'h5500);
    sel_i <= 4'h3;
    wb(1'b0, PFCC_OFF_XON, 32'h0);
    check(rd, {16'h0, 8'h55, PFCC_XON_RST[7:0]}); // byte lanes
    wb(1'b1, PFCC_OFF_XOFF, 32'h4);
    wb(1'b1, PFCC_OFF_XON, 32'h2);
    wb(1'b1, PFCC_OFF_PTIME, {16'h0, pq});
    wb(1'b1, PFCC_OFF_NODROP, 32'(8'(1 << c)));
    wb(1'b0, PFCC_OFF_NODROP, 32'h0);
    check(rd, 32'(8'(1 << c))); // class setting
    wb(1'b1, PFCC_OFF_CTRL, 32'h1);
    push(1'b1, 3'(c + 1), 6);
    repeat (8) @(posedge clk_i);
    check(taken, n0); // drop class silent
    push(1'b1, 3'(c), 4);
    wait_req(8'(1 << c), 8'(1 << c)); // class paused
    check(last.quanta, pq); // pause time
    wb(1'b0, PFCC_OFF_STAT, 32'h0);
    check(rd[7:0], 8'(1 << c)); // class requested
    push(1'b0, 3'(c), 2);
    wait_req(8'(1 << c), 8'h00); // zero time resume
    $display("test thresholds done");
    // Received per-priority pause
    vec <= 8'($urandom) | 8'h01;
    @(posedge clk_i);
    pause(1'b1, vec, 16'h0003);
    check(tx_hold_o, vec); // only named classes
    for (len = 0; len < 40 && tx_hold_o != 8'h00; len++) @(posedge clk_i);
    check(len >= 3 && len <= 8, 1'b1); // hold length
    $display("test received pause done");
    finish_test();
  end
endmodule // pfcc_ctrl_tb
